/* File: hdl/pdpr_pkg.sv */
// Port data and pin readback: shared constants.
// Assumes a 32-bit APB slave with each register in one aligned word.
package pdpr_pkg;

    // Printed register offsets, kept as word indexes (byte address = 4*idx)
    localparam logic [31:0] PA_DATA_IDX     = 32'hffffd102;
    localparam logic [31:0] PA_STATE_IDX    = 32'hffffd11e;
    localparam logic [31:0] PB_DATA_HI_IDX  = 32'hffffd180;
    localparam logic [31:0] PB_DATA_LO_IDX  = 32'hffffd182;
    localparam logic [31:0] PB_STATE_HI_IDX = 32'hffffd19c;
    localparam logic [31:0] PB_STATE_LO_IDX = 32'hffffd19e;
    // Direction registers
    localparam logic [31:0] PA_DIR_HI_IDX   = 32'hffffd108;
    localparam logic [31:0] PA_DIR_LO_IDX   = 32'hffffd10a;
    localparam logic [31:0] PB_DIR_HI_IDX   = 32'hffffd188;
    localparam logic [31:0] PB_DIR_LO_IDX   = 32'hffffd18a;

    // Widths
    localparam int PA_W  = 16;
    localparam int PB_W  = 5;
    localparam int REG_W = 16;

    // Reset values
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [15:0] DIR_RST  = 16'h0000;

    // Implemented bits, full and reduced variants
    localparam logic [15:0] PA_MASK_FULL    = 16'hffff;
    localparam logic [15:0] PA_MASK_RED     = 16'h03db;
    localparam logic [31:0] PB_IMG_MASK_FULL = 32'h0001002e;
    localparam logic [31:0] PB_IMG_MASK_RED  = 32'h0000002a;
    localparam logic [4:0]  PB_PIN_MASK_FULL = 5'h1f;
    localparam logic [4:0]  PB_PIN_MASK_RED  = 5'h0d;

    // Bit position of port B pin n inside the {high,low} image
    localparam int PB_POS [0:4] = '{1, 2, 3, 5, 16};

endpackage

/* File: hdl/pdpr_sync.sv */
// Port data and pin readback: pin input synchroniser.
// Assumes asynchronous pin levels; three stages, change taken on agreement.
`timescale 1ns/1ns
`default_nettype none
module pdpr_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Raw and settled levels
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    import pdpr_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } pdpr_sync_s;

    pdpr_sync_s st_reg;
    pdpr_sync_s st_next;
    logic [W-1:0] agree;

    // Stage one feeds stage two only; the filter looks at two and three
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = din;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        agree      = ~(st_reg.s2 ^ st_reg.s3);
        st_next.q  = (agree & st_reg.s3) | (~agree & st_reg.q);
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dout = st_reg.q;
endmodule
`default_nettype wire

/* File: hdl/pdpr_top.sv */
// Port data and pin readback for ports A and B, APB register slave.
// Assumes pin function selection arrives as per-pin inputs from outside.
//
// Functional notes
// - Direction 0 with general input: reads give the pin, writes store.
// - Direction 0 with another function: reads give the pin, no drive.
// - Direction 1 with general output: stored bit drives, read it back.
// - Direction 1 with another function: read stored bit, pin untouched.
// - Port A pin-state register shows live pins whatever the function.
// - Writes to pin-state registers are ignored.
// - Full variant maps pin-state bits 15..0 onto port A pins 15..0.
// - Reduced variant implements only bits 9..6, 4, 3, 1 and 0.
// - Reduced variant reads bits 15..10, 5 and 2 as zero.
// - Port B has five pins in full and three in reduced variant.
// - Port B data registers are read-write and reset to zero.
// - Port B high pin-state register is read-only, any access width.
// - Port B low pin-state register is read-only, 8 or 16 bit only.
// - Port B data registers behave like port A data.
// - Port A data register is 16 bits read-write, reset to zero.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module pdpr_top #(
    parameter bit FULL_VARIANT = 1'b1
) (
    // Clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // APB slave
    input  wire logic [31:0]               paddr,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Port A pins and function select
    input  wire logic [pdpr_pkg::PA_W-1:0] pa_pin_in,
    output logic      [pdpr_pkg::PA_W-1:0] pa_pin_out,
    output logic      [pdpr_pkg::PA_W-1:0] pa_pin_oe,
    input  wire logic [pdpr_pkg::PA_W-1:0] pa_func_gpio,
    input  wire logic [pdpr_pkg::PA_W-1:0] pa_periph_out,
    input  wire logic [pdpr_pkg::PA_W-1:0] pa_periph_oe,
    // Port B pins (PB1, PB2, PB3, PB5, PB16) and function select
    input  wire logic [pdpr_pkg::PB_W-1:0] pb_pin_in,
    output logic      [pdpr_pkg::PB_W-1:0] pb_pin_out,
    output logic      [pdpr_pkg::PB_W-1:0] pb_pin_oe,
    input  wire logic [pdpr_pkg::PB_W-1:0] pb_func_gpio,
    input  wire logic [pdpr_pkg::PB_W-1:0] pb_periph_out,
    input  wire logic [pdpr_pkg::PB_W-1:0] pb_periph_oe
);
    import pdpr_pkg::*;

    typedef struct packed {
        logic [15:0] pa_data;
        logic [15:0] pa_dir;
        logic [31:0] pb_data;
        logic [31:0] pb_dir;
        logic [15:0] pa_out;
        logic [15:0] pa_oe;
        logic [4:0]  pb_out;
        logic [4:0]  pb_oe;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } pdpr_state_s;

    localparam logic [15:0] PA_MASK  = FULL_VARIANT ? PA_MASK_FULL
                                                    : PA_MASK_RED;
    localparam logic [31:0] PB_IMG_M = FULL_VARIANT ? PB_IMG_MASK_FULL
                                                    : PB_IMG_MASK_RED;
    localparam logic [4:0]  PB_PIN_M = FULL_VARIANT ? PB_PIN_MASK_FULL
                                                    : PB_PIN_MASK_RED;

    pdpr_state_s st_reg;
    pdpr_state_s st_next;

    logic [15:0] pa_sync;
    logic [4:0]  pb_sync;
    logic [15:0] pa_rd;
    logic [31:0] pb_img;
    logic [31:0] pb_rd;
    logic        setup;
    logic        wr;

    // Word match on the index; upper index bits fall off the bus
    function automatic logic hit(input logic [31:0] a,
                                 input logic [31:0] idx);
        hit = (a[31:2] == idx[29:0]);
    endfunction

    // Byte-lane merge into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  strb);
        merge16 = old;
        if (strb[0]) begin
            merge16[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            merge16[15:8] = wd[15:8];
        end
    endfunction

    // Spread the five port B pins into the {high,low} image
    function automatic logic [31:0] pb_spread(input logic [4:0] v);
        pb_spread = '0;
        for (int i = 0; i < PB_W; i++) begin
            pb_spread[PB_POS[i]] = v[i];
        end
    endfunction

    // Gather the five port B pins from the image
    function automatic logic [4:0] pb_gather(input logic [31:0] v);
        pb_gather = '0;
        for (int i = 0; i < PB_W; i++) begin
            pb_gather[i] = v[PB_POS[i]];
        end
    endfunction

    // Pin synchronisers ahead of every read path
    pdpr_sync #(.W(PA_W)) u_sync_a (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (pa_pin_in),
        .dout    (pa_sync)
    );
    pdpr_sync #(.W(PB_W)) u_sync_b (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (pb_pin_in),
        .dout    (pb_sync)
    );

    // Data readback: pin for direction 0, stored bit for direction 1
    assign pa_rd  = PA_MASK & ((st_reg.pa_dir & st_reg.pa_data)
                  | (~st_reg.pa_dir & pa_sync));
    assign pb_img = PB_IMG_M & pb_spread(pb_sync);
    assign pb_rd  = PB_IMG_M & ((st_reg.pb_dir & st_reg.pb_data)
                  | (~st_reg.pb_dir & pb_img));

    // APB phases; one wait-free access cycle
    assign setup = psel & ~penable;
    assign wr    = psel & penable & st_reg.pready & pwrite;

    // Next state: bus answer, register writes, pin drive
    always_comb begin
        logic [31:0] rd;
        logic        err;
        logic        lo_only;
        logic [31:0] pb_w;
        rd      = '0;
        err     = 1'b0;
        lo_only = 1'b1;
        pb_w    = '0;
        st_next = st_reg;
        st_next.pready = setup;
        // Read mux, settled in the setup cycle
        if (hit(paddr, PA_DATA_IDX)) begin
            rd[15:0] = pa_rd;
        end else if (hit(paddr, PA_STATE_IDX)) begin
            rd[15:0] = pa_sync & PA_MASK;
        end else if (hit(paddr, PA_DIR_HI_IDX)) begin
            rd = '0;
        end else if (hit(paddr, PA_DIR_LO_IDX)) begin
            rd[15:0] = st_reg.pa_dir;
        end else if (hit(paddr, PB_DATA_HI_IDX)) begin
            rd[15:0] = pb_rd[31:16];
            lo_only  = 1'b0;
        end else if (hit(paddr, PB_DATA_LO_IDX)) begin
            rd[15:0] = pb_rd[15:0];
        end else if (hit(paddr, PB_STATE_HI_IDX)) begin
            rd[15:0] = pb_img[31:16];
            lo_only  = 1'b0;
        end else if (hit(paddr, PB_STATE_LO_IDX)) begin
            rd[15:0] = pb_img[15:0];
        end else if (hit(paddr, PB_DIR_HI_IDX)) begin
            rd[15:0] = st_reg.pb_dir[31:16];
            lo_only  = 1'b0;
        end else if (hit(paddr, PB_DIR_LO_IDX)) begin
            rd[15:0] = st_reg.pb_dir[15:0];
        end else begin
            err = 1'b1;
        end
        // Wide writes are refused to every word except the three port B high words
        if (pwrite && lo_only && (pstrb[3:2] != 2'b00)) begin
            err = 1'b1;
        end
        if (setup) begin
            st_next.prdata  = pwrite ? 32'h0000_0000 : rd;
            st_next.pslverr = err;
        end
        // Writes land at the access edge; data is stored whatever the mode
        if (wr && !st_reg.pslverr) begin
            if (hit(paddr, PA_DATA_IDX)) begin
                st_next.pa_data = PA_MASK & merge16(st_reg.pa_data,
                                  pwdata, pstrb);
            end else if (hit(paddr, PA_DIR_LO_IDX)) begin
                st_next.pa_dir = PA_MASK & merge16(st_reg.pa_dir,
                                 pwdata, pstrb);
            end else if (hit(paddr, PB_DATA_HI_IDX)) begin
                pb_w = {merge16(st_reg.pb_data[31:16], pwdata, pstrb),
                        st_reg.pb_data[15:0]};
                st_next.pb_data = PB_IMG_M & pb_w;
            end else if (hit(paddr, PB_DATA_LO_IDX)) begin
                pb_w = {st_reg.pb_data[31:16],
                        merge16(st_reg.pb_data[15:0], pwdata, pstrb)};
                st_next.pb_data = PB_IMG_M & pb_w;
            end else if (hit(paddr, PB_DIR_HI_IDX)) begin
                pb_w = {merge16(st_reg.pb_dir[31:16], pwdata, pstrb),
                        st_reg.pb_dir[15:0]};
                st_next.pb_dir = PB_IMG_M & pb_w;
            end else if (hit(paddr, PB_DIR_LO_IDX)) begin
                pb_w = {st_reg.pb_dir[31:16],
                        merge16(st_reg.pb_dir[15:0], pwdata, pstrb)};
                st_next.pb_dir = PB_IMG_M & pb_w;
            end
            // Pin-state words take no write at all
        end
        // Pin drive: general function uses data and direction
        st_next.pa_out = PA_MASK & ((pa_func_gpio & st_next.pa_data)
                       | (~pa_func_gpio & pa_periph_out));
        st_next.pa_oe  = PA_MASK & ((pa_func_gpio & st_next.pa_dir)
                       | (~pa_func_gpio & pa_periph_oe));
        st_next.pb_out = PB_PIN_M & ((pb_func_gpio
                       & pb_gather(st_next.pb_data))
                       | (~pb_func_gpio & pb_periph_out));
        st_next.pb_oe  = PB_PIN_M & ((pb_func_gpio
                       & pb_gather(st_next.pb_dir))
                       | (~pb_func_gpio & pb_periph_oe));
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg         <= '0;
            st_reg.pa_data <= DATA_RST;
            st_reg.pa_dir  <= DIR_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign prdata     = st_reg.prdata;
    assign pready     = st_reg.pready;
    assign pslverr    = st_reg.pslverr;
    assign pa_pin_out = st_reg.pa_out;
    assign pa_pin_oe  = st_reg.pa_oe;
    assign pb_pin_out = st_reg.pb_out;
    assign pb_pin_oe  = st_reg.pb_oe;

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_rd_input;
        setup && !pwrite && hit(paddr, PA_DATA_IDX)
            && st_reg.pa_dir == 16'h0000
        |=> prdata[15:0] == ($past(pa_sync) & PA_MASK);
    endproperty
    a_rd_input: assert property (p_rd_input)
        else $error("input pin read did not return pin level");

    property p_wr_no_drive;
        wr && hit(paddr, PA_DATA_IDX) && st_reg.pa_dir == 16'h0000
            && pa_periph_oe == 16'h0000
        |=> pa_pin_oe == 16'h0000;
    endproperty
    a_wr_no_drive: assert property (p_wr_no_drive)
        else $error("write drove an input pin");

    property p_out_drive;
        st_reg.pa_dir == 16'hffff && pa_func_gpio == 16'hffff
        |=> pa_pin_out == (st_reg.pa_data & PA_MASK)
            && pa_pin_oe == (st_reg.pa_dir & PA_MASK);
    endproperty
    a_out_drive: assert property (p_out_drive)
        else $error("output pin not driven by stored data");

    property p_other_func;
        st_reg.pa_dir == 16'hffff && pa_func_gpio == 16'h0000
        |=> pa_pin_out == ($past(pa_periph_out) & PA_MASK);
    endproperty
    a_other_func: assert property (p_other_func)
        else $error("stored data reached a pin of another function");

    property p_state_read;
        setup && !pwrite && hit(paddr, PA_STATE_IDX)
        |=> prdata == {16'h0000, $past(pa_sync) & PA_MASK} && !pslverr;
    endproperty
    a_state_read: assert property (p_state_read)
        else $error("pin-state read mismatch");

    property p_state_wr;
        wr && hit(paddr, PA_STATE_IDX)
        |=> $stable(st_reg.pa_data) && $stable(st_reg.pa_dir);
    endproperty
    a_state_wr: assert property (p_state_wr)
        else $error("pin-state write changed a register");

    property p_reserved;
        setup && !pwrite
        |=> (prdata[15:0] & ~PA_MASK) == 16'h0000
            || !$past(hit(paddr, PA_STATE_IDX));
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("unimplemented pin-state bit read as one");

    property p_pb_write;
        wr && !pslverr && hit(paddr, PB_DATA_LO_IDX) && pstrb == 4'h3
        |=> st_reg.pb_data[15:0] == ($past(pwdata[15:0])
                                     & PB_IMG_M[15:0]);
    endproperty
    a_pb_write: assert property (p_pb_write)
        else $error("port B low data write not stored");

    property p_hi_wide;
        setup && hit(paddr, PB_STATE_HI_IDX) |=> pready && !pslverr;
    endproperty
    a_hi_wide: assert property (p_hi_wide)
        else $error("high pin-state access refused");

    property p_lo_wide;
        setup && pwrite && hit(paddr, PB_STATE_LO_IDX)
            && pstrb[3:2] != 2'b00
        |=> pslverr ##1 $stable(st_reg.pb_data);
    endproperty
    a_lo_wide: assert property (p_lo_wide)
        else $error("wide low pin-state access not refused");

    property p_pb_pins;
        (pb_pin_oe & ~PB_PIN_M) == 5'h00;
    endproperty
    a_pb_pins: assert property (p_pb_pins)
        else $error("absent port B pin driven");
endmodule
`default_nettype wire

/* File: verif/pdpr_pins.sv */
// Pin-side model: the external circuit on the port pins.
// Assumes the block drives a pin only while its enable is high.
`timescale 1ns/1ns
`default_nettype none
module pdpr_pins #(
    parameter int W = 1
) (
    // Block drive
    input  wire logic [W-1:0] pin_out,
    input  wire logic [W-1:0] pin_oe,
    // Pull level of undriven lines
    input  wire logic [W-1:0] pull,
    // Level seen by the block
    output logic      [W-1:0] pin_in
);
    // Released lines fall to the pull, never hold the last drive
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & pull);
endmodule
`default_nettype wire

/* File: verif/pdpr_top_tb.sv */
// Testbench for port data and pin readback, full and reduced variants.
// Assumes zero-wait APB answers and pin sync within eight clocks.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    fails++; $display("mismatch %s exp %h got %h", n, e, g); end end
module pdpr_top_tb;
    import pdpr_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [31:0] paddr = '0;
    logic        psel_f = 1'b0;
    logic        psel_r = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic [3:0]  pstrb = '0;
    logic [31:0] rd_f, rd_r, rd;
    logic        rdy_f, rdy_r, err_f, err_r, er;
    logic [15:0] pa_in, pa_out, pa_oe, pa_pull = '0;
    logic [15:0] pa_gpio = '1, pa_po = '0, pa_poe = '0;
    logic [4:0]  pb_in, pb_out, pb_oe, pb_pull = '0;
    logic [4:0]  pb_gpio = '1, pb_po = '0, pb_poe = '0;
    logic        red = 1'b0;
    int          fails = 0;
    int          checks_done = 0;

    // 125 MHz clock
    always #4 pclk = ~pclk;

    // Full variant with pin models; reduced one reads the pulls directly
    pdpr_top #(.FULL_VARIANT(1'b1)) pdpr_top_i (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel_f),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(rd_f), .pready(rdy_f), .pslverr(err_f),
        .pa_pin_in(pa_in), .pa_pin_out(pa_out), .pa_pin_oe(pa_oe),
        .pa_func_gpio(pa_gpio), .pa_periph_out(pa_po), .pa_periph_oe(pa_poe),
        .pb_pin_in(pb_in), .pb_pin_out(pb_out), .pb_pin_oe(pb_oe),
        .pb_func_gpio(pb_gpio), .pb_periph_out(pb_po), .pb_periph_oe(pb_poe));
    pdpr_top #(.FULL_VARIANT(1'b0)) pdpr_top_red_i (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel_r),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(rd_r), .pready(rdy_r), .pslverr(err_r),
        .pa_pin_in(pa_pull), .pa_pin_out(), .pa_pin_oe(),
        .pa_func_gpio(pa_gpio), .pa_periph_out(pa_po), .pa_periph_oe(pa_poe),
        .pb_pin_in(pb_pull), .pb_pin_out(), .pb_pin_oe(),
        .pb_func_gpio(pb_gpio), .pb_periph_out(pb_po), .pb_periph_oe(pb_poe));
    pdpr_pins #(.W(16)) pdpr_pins_i (.pin_out(pa_out), .pin_oe(pa_oe),
        .pull(pa_pull), .pin_in(pa_in));
    pdpr_pins #(.W(5)) pdpr_pins_b_i (.pin_out(pb_out), .pin_oe(pb_oe),
        .pull(pb_pull), .pin_in(pb_in));

    // One APB transfer; the request holds until pready is seen high or 20 clocks pass
    task automatic apb(input logic w, input logic [31:0] idx,
                       input logic [31:0] wd, input logic [3:0] st);
        int n;
        n = 0;
        @(posedge pclk);
        paddr <= {idx[29:0], 2'b00};
        psel_f <= ~red;
        psel_r <= red;
        pwrite <= w;
        pwdata <= wd;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while ((red ? rdy_r : rdy_f) !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
        end
        rd = red ? rd_r : rd_f;
        er = red ? err_r : err_f;
        psel_f <= 1'b0;
        psel_r <= 1'b0;
        penable <= 1'b0;
    endtask

    // Low-half write; one more edge lets pin outputs land
    task automatic wr(input logic [31:0] idx, input logic [15:0] d);
        apb(1'b1, idx, {16'h0, d}, 4'h3);
        @(posedge pclk);
    endtask

    task automatic rc(input string n, input logic [31:0] idx,
                      input logic [31:0] e);
        apb(1'b0, idx, 32'h0, 4'h0);
        `CHK(n, e, rd)
    endtask

    // Pin changes need the synchroniser to pass
    task automatic settle;
        repeat (8) @(posedge pclk);
    endtask

    // Reset values read with all pins as outputs and pulled high
    task automatic t_reset;
        @(posedge pclk);
        pa_pull <= 16'hffff;
        pb_pull <= 5'h1f;
        wr(PA_DIR_LO_IDX, 16'hffff);
        wr(PB_DIR_LO_IDX, 16'h002e);
        wr(PB_DIR_HI_IDX, 16'h0001);
        `CHK("pa_out", 16'h0, pa_out)
        `CHK("pb_oe", 5'h1f, pb_oe)
        rc("pa_data", PA_DATA_IDX, 32'h0);
        rc("pb_lo", PB_DATA_LO_IDX, 32'h0);
        rc("pb_hi", PB_DATA_HI_IDX, 32'h0);
        wr(PA_DIR_LO_IDX, 16'h0);
        wr(PB_DIR_LO_IDX, 16'h0);
        wr(PB_DIR_HI_IDX, 16'h0);
    endtask

    // Port A data in all four direction and function cases
    task automatic t_port_a;
        @(posedge pclk);
        pa_pull <= 16'h3c5a;
        wr(PA_DATA_IDX, 16'ha5c3);
        settle;
        `CHK("pa_oe_in", 16'h0, pa_oe)
        rc("pa_in", PA_DATA_IDX, 32'h3c5a);
        @(posedge pclk);
        pa_gpio <= 16'h0;
        pa_po <= 16'h0ff0;
        rc("pa_fn", PA_DATA_IDX, 32'h3c5a);
        `CHK("pa_fn_oe", 16'h0, pa_oe)
        wr(PA_DIR_LO_IDX, 16'hff00);
        settle;
        rc("pa_fn_mix", PA_DATA_IDX, 32'ha55a);
        `CHK("pa_fn_out", 16'h0ff0, pa_out)
        @(posedge pclk);
        pa_gpio <= 16'hffff;
        pa_pull <= 16'hffff;
        settle;
        `CHK("pa_out", 16'ha5c3, pa_out)
        `CHK("pa_oe", 16'hff00, pa_oe)
        rc("pa_mix", PA_DATA_IDX, 32'ha5ff);
        apb(1'b1, PA_DATA_IDX, 32'h1234, 4'h2);
        @(posedge pclk);
        `CHK("pa_lane", 16'h12c3, pa_out)
        wr(PA_DIR_LO_IDX, 16'h0);
    endtask

    // Pin-state registers: function ignored, bit order, writes ignored
    task automatic t_state;
        @(posedge pclk);
        pa_pull <= 16'h8003;
        pa_gpio <= 16'h0;
        settle;
        rc("pa_st", PA_STATE_IDX, 32'h8003);
        wr(PA_STATE_IDX, 16'h7ffc);
        `CHK("st_err", 1'b0, er)
        rc("pa_st_wr", PA_STATE_IDX, 32'h8003);
        wr(PA_DIR_LO_IDX, 16'hffff);
        `CHK("pa_fn_po", 16'h0ff0, pa_out)
        wr(PA_DIR_LO_IDX, 16'h0);
        apb(1'b1, PB_STATE_LO_IDX, 32'hffff, 4'hf);
        `CHK("pb_st_lo_w", 1'b1, er)
        apb(1'b1, PB_STATE_HI_IDX, 32'hffff, 4'hf);
        `CHK("pb_st_hi_w", 1'b0, er)
        apb(1'b0, 32'hffffd1f0, 32'h0, 4'h0);
        `CHK("unmapped", 1'b1, er)
        @(posedge pclk);
        pa_gpio <= 16'hffff;
    endtask

    // Port B image, drive and wide-write refusal
    task automatic t_port_b;
        @(posedge pclk);
        pb_pull <= 5'h15;
        settle;
        rc("pb_in_lo", PB_DATA_LO_IDX, 32'h000a);
        rc("pb_in_hi", PB_DATA_HI_IDX, 32'h0001);
        rc("pb_st_lo", PB_STATE_LO_IDX, 32'h000a);
        rc("pb_st_hi", PB_STATE_HI_IDX, 32'h0001);
        wr(PB_DATA_LO_IDX, 16'hffd4);
        wr(PB_DATA_HI_IDX, 16'hfffe);
        wr(PB_DIR_LO_IDX, 16'h002e);
        wr(PB_DIR_HI_IDX, 16'h0001);
        `CHK("pb_out", 5'h02, pb_out)
        rc("pb_rd_lo", PB_DATA_LO_IDX, 32'h0004);
        apb(1'b1, PB_DATA_LO_IDX, 32'h0020, 4'hf);
        `CHK("pb_lo_wide", 1'b1, er)
        rc("pb_rd_lo2", PB_DATA_LO_IDX, 32'h0004);
    endtask

    // Reduced variant: missing bits read zero
    task automatic t_reduced;
        @(posedge pclk);
        red <= 1'b1;
        pa_pull <= 16'hffff;
        pb_pull <= 5'h1f;
        settle;
        rc("red_st", PA_STATE_IDX, 32'h03db);
        rc("red_pb_lo", PB_DATA_LO_IDX, 32'h002a);
        rc("red_pb_hi", PB_DATA_HI_IDX, 32'h0000);
        wr(PA_DATA_IDX, 16'hffff);
        wr(PA_DIR_LO_IDX, 16'hffff);
        rc("red_data", PA_DATA_IDX, 32'h03db);
        wr(PB_DIR_LO_IDX, 16'h002e);
        wr(PB_DIR_HI_IDX, 16'h0001);
        rc("red_pb_dir", PB_DIR_LO_IDX, 32'h002a);
    endtask

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        fails++;
        give_verdict;
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_port_a;
        t_state;
        t_port_b;
        t_reduced;
        give_verdict;
    end
endmodule
`default_nettype wire
